// File: rtl/flash_status_params.svh
// Purpose: constants of the serial flash status and protection front end
// Assumes: included by the package and the design file
// Notes: definitions only
`ifndef FLASH_STATUS_PARAMS_SVH
`define FLASH_STATUS_PARAMS_SVH

// ============================================================
// status register field positions and reset value
`define SR_BUSY 0
`define SR_WEL 1
`define SR_BP_LO 2
`define SR_BP_HI 3
`define SR_AUTO 6
`define SR_LOCK 7
`define SR_RESET 8'h0C

// ============================================================
// instruction codes
`define OP_READ_STATUS 8'h05
`define OP_STATUS_WRITE 8'h01
`define OP_STATUS_UNLOCK 8'h50
`define OP_WRITE_EN 8'h06
`define OP_WRITE_DIS 8'h04
`define OP_BYTE_PROG 8'h02
`define OP_AUTO_PROG 8'hAF
`define OP_SECTOR_ERASE 8'h20
`define OP_BLOCK_ERASE 8'h52
`define OP_CHIP_ERASE 8'h60

// ============================================================
// protected region bases and top of the array
`define QUARTER_BASE 16'hC000
`define HALF_BASE 16'h8000
`define TOP_ADDR 16'hFFFF

// ============================================================
// busy durations in core clock cycles
`define PROG_CYCLES 16'h0040
`define ERASE_CYCLES 16'h0100
`define CHIP_CYCLES 16'h0400

`endif

// File: rtl/flash_status_pkg.sv
// Purpose: types shared by the flash status front end
// Assumes: constants come from flash_status_params.svh
// Notes: no timing or offsets here
`include "flash_status_params.svh"

package flash_status_pkg;

   // ============================================================
   // kind of array operation handed to the memory core
   typedef enum logic [2:0] {OPK_NONE, OPK_PROG, OPK_SECTOR, OPK_BLOCK, OPK_CHIP} array_op_e;

   // ============================================================
   // internal operation state
   typedef enum logic {CORE_IDLE, CORE_BUSY} core_state_e;

endpackage : flash_status_pkg

// File: rtl/serial_flash_status_protect.sv
// Purpose: serial front end, pause, write protection and status register
// Assumes: sck is the link clock, core_clk runs the status and busy timer
// Notes: frame fields are read by the core only after select is seen high
`timescale 1ns/10ps
`include "flash_status_params.svh"

module serial_flash_status_protect
   import flash_status_pkg::*;
(
   input wire logic core_clk, // core clock, 40 MHz
   input wire logic resetn, // power-up reset, active low
   input wire logic sck, // serial clock from host
   input wire logic ce_n, // device select, active low
   input wire logic si, // serial data in
   input wire logic hold_n, // pause request, active low
   input wire logic wp_n, // write protect pin, active low
   output logic so_out, // serial data out level
   output logic so_oe, // serial data out enable
   output logic array_go, // one-cycle start of an array operation
   output array_op_e array_kind, // kind of array operation
   output logic [15:0] array_addr, // array byte address
   output logic [7:0] array_data // byte to program
);

   // ============================================================
   // link side: shifting and frame capture on sck
   logic [2:0] bit_cnt;
   logic [2:0] byte_idx;
   logic [2:0] nbytes;
   logic [7:0] shift;
   logic [7:0] frame_byte [0:4];
   logic mid_byte;
   logic frame_tgl;
   logic [7:0] stat_s1;
   logic [7:0] stat_s2;
   logic [7:0] stat_s3;
   logic [7:0] stat_view;
   logic [7:0] stat_pub;

   // deselect clears the interface counters, also while paused
   wire link_clr = ce_n | ~resetn;
   wire shift_en = hold_n;
   wire [7:0] next_shift = {shift[6:0], si};
   wire byte_done = shift_en & (bit_cnt == 3'h7);
   wire [2:0] next_nbytes = (byte_idx == 3'h5) ? 3'h5 : byte_idx + 3'h1;
   wire rd_status = (frame_byte[0] == `OP_READ_STATUS) & (byte_idx != 3'h0);

   always_ff @(posedge sck or posedge link_clr) begin
      if (link_clr) begin
         bit_cnt <= 3'h0;
         byte_idx <= 3'h0;
      end else if (shift_en) begin
         bit_cnt <= bit_cnt + 3'h1;
         if (bit_cnt == 3'h7 && byte_idx != 3'h5) begin
            byte_idx <= byte_idx + 3'h1;
         end
      end
   end

   // these survive deselect so the core can read them after the frame
   always_ff @(posedge sck or negedge resetn) begin
      if (!resetn) begin
         shift <= 8'h00;
         mid_byte <= 1'b0;
         frame_tgl <= 1'b0;
         nbytes <= 3'h0;
      end else if (shift_en) begin
         shift <= next_shift;
         mid_byte <= (bit_cnt != 3'h7);
         if (byte_done) begin
            nbytes <= next_nbytes;
         end
         if (byte_done && byte_idx == 3'h0) begin
            frame_tgl <= ~frame_tgl;
         end
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < 5; gi++) begin : g_frame
         always_ff @(posedge sck or negedge resetn) begin
            if (!resetn) begin
               frame_byte[gi] <= 8'h00;
            end else if (byte_done && byte_idx == 3'(gi)) begin
               frame_byte[gi] <= next_shift;
            end
         end
      end
   endgenerate

   // status copy: two-stage sync plus a third stage; a view is only taken when
   // the last two agree, so a word caught mid-change is never shown
   always_ff @(posedge sck or negedge resetn) begin
      if (!resetn) begin
         stat_s1 <= `SR_RESET;
         stat_s2 <= `SR_RESET;
         stat_s3 <= `SR_RESET;
         stat_view <= `SR_RESET;
      end else begin
         stat_s1 <= stat_pub;
         stat_s2 <= stat_s1;
         stat_s3 <= stat_s2;
         if (byte_done && stat_s2 == stat_s3) begin
            stat_view <= stat_s3;
         end
      end
   end

   // output moves on the falling edge; first falling edge of an idle-high frame
   // finds byte_idx zero and leaves the pin off
   always_ff @(negedge sck or posedge link_clr) begin
      if (link_clr) begin
         so_oe <= 1'b0;
         so_out <= 1'b0;
      end else begin
         so_oe <= rd_status & hold_n;
         if (hold_n) begin
            so_out <= stat_view[3'h7 - bit_cnt];
         end
      end
   end

   // ============================================================
   // core side: synchronisers
   logic ce_q1;
   logic ce_q2;
   logic ce_q3;
   logic tgl_q1;
   logic tgl_q2;
   logic tgl_seen;
   logic wp_q1;
   logic wp_q2;

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         ce_q1 <= 1'b1;
         ce_q2 <= 1'b1;
         ce_q3 <= 1'b1;
         tgl_q1 <= 1'b0;
         tgl_q2 <= 1'b0;
         wp_q1 <= 1'b1;
         wp_q2 <= 1'b1;
      end else begin
         ce_q1 <= ce_n;
         ce_q2 <= ce_q1;
         ce_q3 <= ce_q2;
         tgl_q1 <= frame_tgl;
         tgl_q2 <= tgl_q1;
         wp_q1 <= wp_n;
         wp_q2 <= wp_q1;
      end
   end

   // ============================================================
   // core side: decode of a finished frame
   core_state_e state;
   logic write_enable_latch;
   logic [1:0] bp;
   logic auto_mode;
   logic protect_lock;
   logic unlock_armed;
   logic cur_auto;
   logic [15:0] busy_cnt;
   logic [15:0] auto_addr;

   function automatic logic in_guard(input logic [1:0] lvl, input array_op_e k,
                                     input logic [15:0] a);
      logic hit;
      hit = 1'b0;
      case (lvl)
         2'b00: hit = 1'b0;
         2'b01: hit = (k != OPK_BLOCK) && (a >= `QUARTER_BASE);
         2'b10: hit = (a >= `HALF_BASE);
         default: hit = 1'b1;
      endcase
      return hit;
   endfunction : in_guard

   wire busy = (state == CORE_BUSY);
   wire frame_end = ce_q2 & ~ce_q3;
   wire frame_ok = frame_end & (tgl_q2 != tgl_seen) & ~mid_byte;
   wire idle_cmd = frame_ok & ~busy;
   wire [7:0] op = frame_byte[0];
   wire [15:0] frame_addr = {frame_byte[2], frame_byte[3]};
   wire is_prog = (op == `OP_BYTE_PROG);
   wire is_auto = (op == `OP_AUTO_PROG);
   wire is_sector = (op == `OP_SECTOR_ERASE);
   wire is_block = (op == `OP_BLOCK_ERASE);
   wire is_chip = (op == `OP_CHIP_ERASE);
   wire is_status_write_cmd = (op == `OP_STATUS_WRITE);
   wire auto_cont = is_auto & auto_mode;
   wire [15:0] auto_next = auto_addr + 16'h0001;
   wire [15:0] target = auto_cont ? auto_next : frame_addr;
   // erases hand over a zero byte rather than whatever an older frame left behind
   wire [7:0] target_data = !(is_prog | is_auto) ? 8'h00 :
                            auto_cont ? frame_byte[1] : frame_byte[4];
   wire array_op_e kind = (is_prog | is_auto) ? OPK_PROG :
                          is_sector ? OPK_SECTOR :
                          is_block ? OPK_BLOCK :
                          is_chip ? OPK_CHIP : OPK_NONE;
   wire [2:0] need = auto_cont ? 3'h2 :
                     (is_prog | is_auto) ? 3'h5 :
                     (is_sector | is_block) ? 3'h4 : 3'h1;
   wire enough = (nbytes >= need);
   wire lock_on = protect_lock & ~wp_q2;
   wire guarded = in_guard(bp, kind, target);
   wire chip_ok = ~is_chip | (bp == 2'b00);
   wire start_op = idle_cmd & write_enable_latch & enough & (kind != OPK_NONE) & ~guarded & chip_ok;
   wire status_write_cmd_ok = idle_cmd & is_status_write_cmd & unlock_armed & ~lock_on & (nbytes >= 3'h2);
   wire [15:0] dur = (kind == OPK_PROG) ? `PROG_CYCLES :
                     (kind == OPK_CHIP) ? `CHIP_CYCLES : `ERASE_CYCLES;
   wire [7:0] wr_val = frame_byte[1];

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         tgl_seen <= 1'b0;
         unlock_armed <= 1'b0;
      end else if (frame_end) begin
         tgl_seen <= tgl_q2;
         if (idle_cmd) begin
            unlock_armed <= (op == `OP_STATUS_UNLOCK);
         end
      end
   end

   // ============================================================
   // core side: status fields and the busy timer
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         state <= CORE_IDLE;
         write_enable_latch <= 1'b0;
         bp <= 2'b11;
         auto_mode <= 1'b0;
         protect_lock <= 1'b0;
         cur_auto <= 1'b0;
         busy_cnt <= 16'h0000;
         auto_addr <= 16'h0000;
      end else begin
         case (state)
            CORE_IDLE: begin
               if (idle_cmd && op == `OP_WRITE_EN) begin
                  write_enable_latch <= 1'b1;
               end
               if (idle_cmd && op == `OP_WRITE_DIS) begin
                  write_enable_latch <= 1'b0;
                  auto_mode <= 1'b0;
               end
               if (status_write_cmd_ok) begin
                  bp <= {wr_val[`SR_BP_HI], wr_val[`SR_BP_LO]};
                  protect_lock <= wr_val[`SR_LOCK];
               end
               if (start_op) begin
                  state <= CORE_BUSY;
                  busy_cnt <= dur - 16'h0001;
                  cur_auto <= is_auto;
                  if (is_auto) begin
                     auto_mode <= 1'b1;
                     auto_addr <= target;
                  end
               end
            end
            CORE_BUSY: begin
               busy_cnt <= busy_cnt - 16'h0001;
               if (busy_cnt == 16'h0000) begin
                  state <= CORE_IDLE;
                  if (!cur_auto || auto_addr == `TOP_ADDR) begin
                     write_enable_latch <= 1'b0;
                  end
                  if (cur_auto && auto_addr == `TOP_ADDR) begin
                     auto_mode <= 1'b0;
                  end
               end
            end
            default: state <= CORE_IDLE;
         endcase
      end
   end

   // ============================================================
   // core side: outputs to the array and the published status word
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         array_go <= 1'b0;
         array_kind <= OPK_NONE;
         array_addr <= 16'h0000;
         array_data <= 8'h00;
         stat_pub <= `SR_RESET;
      end else begin
         array_go <= start_op;
         if (start_op) begin
            array_kind <= kind;
            array_addr <= target;
            array_data <= target_data;
         end
         stat_pub <= {protect_lock, auto_mode, 2'b00, bp, write_enable_latch, busy};
      end
   end

   // ============================================================
   // checks
   sequence s_start;
      array_go;
   endsequence

   sequence s_busy_run;
      busy [*4];
   endsequence

   sequence s_paused_edge;
      !hold_n;
   endsequence

   a_busy_after_go: assert property (
      @(posedge core_clk) disable iff (!resetn) s_start |-> s_busy_run)
      else $error("busy did not stay high after an array start");

   a_go_needs_wel: assert property (
      @(posedge core_clk) disable iff (!resetn) s_start |-> $past(write_enable_latch) && !$past(busy))
      else $error("array start without write latch or while busy");

   a_busy_ignores: assert property (
      @(posedge core_clk) disable iff (!resetn) (busy && frame_ok) |=> !array_go && $stable(bp))
      else $error("command acted on while busy");

   a_chip_clean: assert property (
      @(posedge core_clk) disable iff (!resetn)
      (array_go && array_kind == OPK_CHIP) |-> $past(bp) == 2'b00)
      else $error("chip erase started with guard bits set");

   a_guard_block: assert property (
      @(posedge core_clk) disable iff (!resetn)
      s_start |-> !in_guard($past(bp), array_kind, array_addr))
      else $error("operation started inside protected region");

   a_wel_drop: assert property (
      @(posedge core_clk) disable iff (!resetn) ($fell(busy) && !$past(cur_auto)) |-> !write_enable_latch)
      else $error("write latch still set after completion");

   a_lock_steady: assert property (
      @(posedge core_clk) disable iff (!resetn) lock_on |=> $stable(bp) && $stable(protect_lock))
      else $error("locked guard bits changed");

   // checks the pin itself: bit positions 2 and 3 of a byte carry status bits 5 and 4
   a_reserved_zero: assert property (
      @(posedge sck) disable iff (link_clr)
      (so_oe && bit_cnt[2:1] == 2'h1) |-> !so_out)
      else $error("reserved status bit shifted out as one");

   a_pause_quiet: assert property (
      @(negedge sck) disable iff (link_clr) so_oe |-> $past(hold_n))
      else $error("output driven while paused");

   a_pause_holds: assert property (
      @(posedge sck) disable iff (link_clr) s_paused_edge |=> $stable(bit_cnt))
      else $error("bit position moved while paused");

endmodule : serial_flash_status_protect

// File: dv/flash_host_model.sv
// Purpose: host side of the serial link, sends one frame per call
// Assumes: sck half period 16 ns, clock idles per mode between frames
// Notes: an undriven so line shows a changing level, never the last bit
`timescale 1ns/10ps
module flash_host_model (
   output logic sck, // serial clock to device
   output logic ce_n, // device select, active low
   output logic si, // serial data to device
   output logic hold_n, // pause request, active low
   input wire logic so_out, // device data out level
   input wire logic so_oe, // device data out enable
   output logic hold_oe // set if device drove so while paused
);
   logic mode3;
   logic so_last;
   wire so_line = so_oe ? so_out : ~so_last;

   initial begin
      sck = 1'h0;
      ce_n = 1'h1;
      si = 1'h0;
      hold_n = 1'h1;
      mode3 = 1'h0;
      hold_oe = 1'h0;
      so_last = 1'h0;
   end

   always @(negedge sck) so_last <= so_line;

   // ============================================================
   // frame: nb bytes of tx from the top, pause before bit hb
   task automatic frame(input logic [39:0] tx, input int nb, input int hb,
                        output logic [7:0] rx);
      int i;
      // reach the idle level of the mode before select falls, never in the same step
      sck = mode3;
      #16 ce_n = 1'h0;
      #16;
      for (i = 0; i < nb * 8; i++) begin
         sck = 1'h0;
         if (i == hb) begin
            hold_n = 1'h0;
            repeat (2) begin
               #16 sck = 1'h1;
               #16 sck = 1'h0;
               si = ~si;
            end
            #4 if (so_oe) hold_oe = 1'h1;
            // release while the clock is high so the exit lands on the next low phase
            #12 sck = 1'h1;
            #8 hold_n = 1'h1;
            #8 sck = 1'h0;
         end
         si = tx[39 - i];
         #16 sck = 1'h1;
         rx = {rx[6:0], so_line};
         #16;
      end
      sck = mode3;
      #16 ce_n = 1'h1;
      #200;
   endtask : frame
endmodule : flash_host_model

// File: dv/serial_flash_status_protect_tb.sv
// Purpose: self-checking bench for the flash status front end
// Assumes: host model drives the link, bench drives resets and wp_n
// Notes: rows cover status writes, hand tests cover array starts
`timescale 1ns/10ps
module serial_flash_status_protect_tb;
   import flash_status_pkg::*;
   typedef struct packed {
      logic u;
      logic w;
      logic [2:0] nb;
      logic [39:0] tx;
      logic [7:0] st;
   } row_s;
   logic core_clk;
   logic resetn;
   logic wp_n;
   logic sck, ce_n, si, hold_n, so_out, so_oe, hold_oe, array_go;
   array_op_e array_kind;
   array_op_e last_kind;
   logic [15:0] array_addr;
   logic [15:0] last_addr;
   logic [7:0] array_data;
   logic [7:0] last_data;
   logic [7:0] rx;
   int failures;
   int compares;
   int gos;
   int i;
   row_s rows [8];

   serial_flash_status_protect uut (.core_clk(core_clk), .resetn(resetn), .sck(sck),
      .ce_n(ce_n), .si(si), .hold_n(hold_n), .wp_n(wp_n), .so_out(so_out), .so_oe(so_oe),
      .array_go(array_go), .array_kind(array_kind), .array_addr(array_addr),
      .array_data(array_data));
   flash_host_model host (.sck(sck), .ce_n(ce_n), .si(si), .hold_n(hold_n),
      .so_out(so_out), .so_oe(so_oe), .hold_oe(hold_oe));

   initial core_clk = 1'h0;
   always #12.5 core_clk = ~core_clk;

   always @(posedge core_clk) begin
      if (array_go === 1'h1) begin
         gos <= gos + 1;
         last_kind <= array_kind;
         last_addr <= array_addr;
         last_data <= array_data;
      end
   end

   // ============================================================
   // checks and link helpers
   task automatic complete_run;
      if (failures == 0 && compares > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : complete_run

   task automatic chk(input logic [39:0] got, input logic [39:0] exp);
      compares++;
      if (got !== exp) begin
         failures++;
         $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic chk_go(input int n, input array_op_e k, input logic [15:0] a,
                         input logic [7:0] d);
      chk(n, gos);
      chk({last_kind, last_addr, last_data}, {k, a, d});
   endtask : chk_go

   task automatic send(input logic [39:0] tx, input int nb);
      host.frame(tx, nb, -1, rx);
   endtask : send

   task automatic rd(input int hb);
      host.frame({8'h05, 32'h0}, 2, hb, rx);
   endtask : rd

   // polls status; a device stuck busy ends the run
   task automatic wait_idle;
      int n;
      n = 0;
      rd(-1);
      while (rx[0] !== 1'h0 && n < 100) begin
         rd(-1);
         n++;
      end
      if (rx[0] !== 1'h0) begin
         failures++;
         complete_run();
      end
   endtask : wait_idle

   initial begin
      #2000000;
      failures++;
      complete_run();
   end

   // ============================================================
   // main sequence
   initial begin
      rows = '{'{1'h0, 1'h1, 3'h1, {8'h06, 32'h0}, 8'h0E},
               '{1'h0, 1'h1, 3'h1, {8'h04, 32'h0}, 8'h0C},
               '{1'h0, 1'h1, 3'h2, {8'h01, 8'h00, 24'h0}, 8'h0C},
               '{1'h1, 1'h1, 3'h2, {8'h01, 8'hFC, 24'h0}, 8'h8C},
               '{1'h1, 1'h0, 3'h2, {8'h01, 8'h00, 24'h0}, 8'h8C},
               '{1'h1, 1'h1, 3'h2, {8'h01, 8'h00, 24'h0}, 8'h00},
               '{1'h1, 1'h0, 3'h2, {8'h01, 8'h04, 24'h0}, 8'h04},
               '{1'h0, 1'h0, 3'h1, {8'h06, 32'h0}, 8'h06}};
      failures = 0;
      compares = 0;
      gos = 0;
      resetn = 1'h0;
      wp_n = 1'h1;
      repeat (10) @(negedge core_clk);
      resetn = 1'h1;
      repeat (4) @(negedge core_clk);
      rd(-1);
      chk(rx, 8'h0C);
      for (i = 0; i < 8; i++) begin
         @(negedge core_clk) wp_n = rows[i].w;
         if (rows[i].u) send({8'h50, 32'h0}, 1);
         send(rows[i].tx, rows[i].nb);
         rd(-1);
         chk(rx, rows[i].st);
      end
      // guards at quarter level, latch set, pin low from here
      send({8'h02, 8'h00, 16'hC000, 8'h55}, 5);
      rd(-1);
      chk(gos, 0);
      chk(rx, 8'h06);
      send({8'h52, 8'h00, 16'hC000, 8'h00}, 4);
      rd(-1);
      chk(rx[0], 1'h1);
      send({8'h02, 8'h00, 16'h1000, 8'h77}, 5);
      wait_idle();
      chk(rx, 8'h04);
      chk_go(1, OPK_BLOCK, 16'hC000, 8'h00);
      send({8'h20, 8'h00, 16'h1000, 8'h00}, 4);
      send({8'h06, 32'h0}, 1);
      send({8'h60, 32'h0}, 1);
      rd(-1);
      chk(rx, 8'h06);
      chk(gos, 1);
      send({8'h50, 32'h0}, 1);
      send({8'h01, 8'h00, 24'h0}, 2);
      send({8'h60, 32'h0}, 1);
      rd(-1);
      chk(rx, 8'h03);
      wait_idle();
      chk(rx, 8'h00);
      chk({gos, last_kind}, {32'h2, OPK_CHIP});
      send({8'h06, 32'h0}, 1);
      send({8'hAF, 8'h00, 16'hFFFE, 8'h11}, 5);
      wait_idle();
      chk(rx, 8'h42);
      chk_go(3, OPK_PROG, 16'hFFFE, 8'h11);
      send({8'hAF, 8'h22, 24'h0}, 2);
      wait_idle();
      chk(rx, 8'h00);
      chk_go(4, OPK_PROG, 16'hFFFF, 8'h22);
      host.mode3 = 1'h1;
      send({8'h06, 32'h0}, 1);
      rd(11);
      chk(rx, 8'h02);
      chk(hold_oe, 1'h0);
      send({8'h02, 8'h00, 16'h1234, 8'hAB}, 5);
      wait_idle();
      chk_go(5, OPK_PROG, 16'h1234, 8'hAB);
      // sector erase with no guard: the only start of that kind
      send({8'h06, 32'h0}, 1);
      send({8'h20, 8'h00, 16'h8000, 8'h00}, 4);
      wait_idle();
      chk(rx, 8'h00);
      chk_go(6, OPK_SECTOR, 16'h8000, 8'h00);
      @(negedge core_clk) resetn = 1'h0;
      repeat (10) @(negedge core_clk);
      resetn = 1'h1;
      repeat (4) @(negedge core_clk);
      rd(-1);
      chk(rx, 8'h0C);
      complete_run();
   end
endmodule : serial_flash_status_protect_tb
